// File: logic/uvcmd_decoder.v
// vendor command decoder: classifies setup packets, applies mode commands
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "uvcmd_map.vh"

module uvcmd_decoder #(
	parameter ADDR_W = 3
) (
	input  wire              mclk,
	input  wire              reset_n,
	input  wire              setup_valid,
	input  wire [7:0]        setup_req_type,
	input  wire [7:0]        setup_request,
	input  wire [15:0]       setup_value,
	input  wire [15:0]       setup_index,
	input  wire [15:0]       setup_length,
	input  wire              poll_tick,
	input  wire [ADDR_W-1:0] avs_address,
	input  wire              avs_read,
	input  wire              avs_write,
	input  wire [31:0]       avs_writedata,
	output reg  [31:0]       avs_readdata,
	output reg               avs_waitrequest,
	output reg               cmd_valid_ff,
	output reg  [1:0]        cmd_class_ff,
	output reg  [15:0]       cmd_code_ff,
	output reg  [15:0]       cmd_param_ff,
	output reg  [7:0]        cmd_param_ext_ff,
	output reg               cmd_data_stage_ff,
	output reg               comm_spu_ok_ff,
	output reg               comm_prg_ok_ff,
	output reg               comm_spd_ok_ff,
	output reg               ep0_stall_ff,
	output reg               report_valid_ff,
	output reg  [31:0]       report_state_ff
);
	reg         spu_en_ff;
	reg         prg_en_ff;
	reg         spd_chg_en_ff;
	reg         dec_en_ff;
	reg  [15:0] stall_cnt_ff;
	wire [2:0]  speed;
	wire [7:0]  spu_dur;
	wire [7:0]  prg_dur;
	wire [2:0]  slew;
	wire [2:0]  w1lt;
	wire [2:0]  dso;

	// packet qualification
	wire rt_ok    = (setup_req_type & `UVCMD_RT_MASK) == `UVCMD_RT_VENDOR_DEV;
	wire is_ctl   = setup_request == `UVCMD_REQ_CONTROL;
	wire is_comm  = setup_request == `UVCMD_REQ_COMM;
	wire is_mode  = setup_request == `UVCMD_REQ_MODE;
	wire ctl_ok   = setup_value <= `UVCMD_CTL_LAST;
	wire mode_ok  = setup_value <= `UVCMD_MODE_DSO;
	wire known    = rt_ok && ((is_ctl && ctl_ok) || is_comm || (is_mode && mode_ok));
	wire take     = setup_valid && dec_en_ff;
	wire accept   = take && known;
	wire mode_go  = accept && is_mode;
	wire comm_go  = accept && is_comm;
	wire straight = setup_value[7:0] == `UVCMD_COMM_STRAIGHT;
	wire c_spu    = setup_value[`UVCMD_COMM_SPU_BIT];
	wire c_prg    = setup_value[`UVCMD_COMM_PRG_BIT];
	wire c_spd    = setup_value[`UVCMD_COMM_SPD_BIT] && !straight;

	// setting loads: dedicated mode command or embedded comm value
	wire ld_speed = (mode_go && setup_value == `UVCMD_MODE_SPEED) ||
	                (comm_go && c_spd && spd_chg_en_ff);
	wire ld_spu   = (mode_go && setup_value == `UVCMD_MODE_SPU_DUR) ||
	                (comm_go && c_spu && spu_en_ff && !straight);
	wire ld_prg   = (mode_go && setup_value == `UVCMD_MODE_PRG_DUR) ||
	                (comm_go && c_prg && prg_en_ff && !straight);
	wire ld_slew  = mode_go && setup_value == `UVCMD_MODE_SLEW;
	wire ld_w1lt  = mode_go && setup_value == `UVCMD_MODE_W1LT;
	wire ld_dso   = mode_go && setup_value == `UVCMD_MODE_DSO;

	// embedded comm values: speed in index high byte, duration in index low byte
	wire [2:0] nxt_speed = mode_go ? setup_index[2:0] : setup_index[10:8];

	uvcmd_setting #(.WIDTH(3), .RST_VAL(`UVCMD_SPEED_REGULAR)) u_speed (
		.mclk    (mclk),
		.reset_n (reset_n),
		.load    (ld_speed),
		.nxt_val (nxt_speed),
		.val_ff  (speed)
	);
	uvcmd_setting #(.WIDTH(8), .RST_VAL(`UVCMD_RST_SPU_DUR)) u_spu_dur (
		.mclk    (mclk),
		.reset_n (reset_n),
		.load    (ld_spu),
		.nxt_val (setup_index[7:0]),
		.val_ff  (spu_dur)
	);
	uvcmd_setting #(.WIDTH(8), .RST_VAL(`UVCMD_RST_PRG_DUR)) u_prg_dur (
		.mclk    (mclk),
		.reset_n (reset_n),
		.load    (ld_prg),
		.nxt_val (setup_index[7:0]),
		.val_ff  (prg_dur)
	);
	uvcmd_setting #(.WIDTH(3), .RST_VAL(`UVCMD_RST_SLEW)) u_slew (
		.mclk    (mclk),
		.reset_n (reset_n),
		.load    (ld_slew),
		.nxt_val (setup_index[2:0]),
		.val_ff  (slew)
	);
	uvcmd_setting #(.WIDTH(3), .RST_VAL(`UVCMD_RST_W1LT)) u_w1lt (
		.mclk    (mclk),
		.reset_n (reset_n),
		.load    (ld_w1lt),
		.nxt_val (setup_index[2:0]),
		.val_ff  (w1lt)
	);
	uvcmd_setting #(.WIDTH(3), .RST_VAL(`UVCMD_RST_DSO)) u_dso (
		.mclk    (mclk),
		.reset_n (reset_n),
		.load    (ld_dso),
		.nxt_val (setup_index[2:0]),
		.val_ff  (dso)
	);

	wire [31:0] state_a = {13'h0000, speed, 13'h0000, spd_chg_en_ff, prg_en_ff, spu_en_ff};
	wire [31:0] state_b = {5'h00, dso, 1'b0, w1lt, 1'b0, slew, prg_dur, spu_dur};

	// global enables, settable only by mode command; comm bits never reach them
	reg         nxt_spu_en;
	reg         nxt_prg_en;
	reg         nxt_spd_chg_en;

	always @* begin
		nxt_spu_en     = spu_en_ff;
		nxt_prg_en     = prg_en_ff;
		nxt_spd_chg_en = spd_chg_en_ff;
		if (mode_go && setup_value == `UVCMD_MODE_PULSE_EN) begin
			nxt_spu_en = setup_index[`UVCMD_PE_SPU_BIT];
			nxt_prg_en = setup_index[`UVCMD_PE_PRG_BIT];
		end
		if (mode_go && setup_value == `UVCMD_MODE_SPEED_EN) begin
			// any nonzero parameter counts as true
			nxt_spd_chg_en = |setup_index;
		end
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			spu_en_ff     <= 1'b0;
			prg_en_ff     <= 1'b0;
			spd_chg_en_ff <= 1'b0;
		end else begin
			spu_en_ff     <= nxt_spu_en;
			prg_en_ff     <= nxt_prg_en;
			spd_chg_en_ff <= nxt_spd_chg_en;
		end
	end

	// class code from the request byte; unknown classes never reach the register
	reg  [1:0]  nxt_class;

	always @* begin
		case (setup_request)
		`UVCMD_REQ_MODE: begin
			nxt_class = `UVCMD_CLS_MODE;
		end
		`UVCMD_REQ_COMM: begin
			nxt_class = `UVCMD_CLS_COMM;
		end
		default: begin
			nxt_class = `UVCMD_CLS_CONTROL;
		end
		endcase
	end

	// decoded command outputs
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_valid_ff      <= 1'b0;
			cmd_class_ff      <= `UVCMD_CLS_CONTROL;
			cmd_code_ff       <= 16'h0000;
			cmd_param_ff      <= 16'h0000;
			cmd_param_ext_ff  <= 8'h00;
			cmd_data_stage_ff <= 1'b0;
			comm_spu_ok_ff    <= 1'b0;
			comm_prg_ok_ff    <= 1'b0;
			comm_spd_ok_ff    <= 1'b0;
			ep0_stall_ff      <= 1'b0;
		end else begin
			cmd_valid_ff <= accept;
			ep0_stall_ff <= take && !known;
			if (accept) begin
				cmd_class_ff <= nxt_class;
				cmd_param_ff <= setup_index;
				if (is_comm && straight) begin
					cmd_code_ff      <= {8'h00, setup_value[7:0]};
					cmd_param_ext_ff <= setup_value[15:8];
				end else begin
					cmd_code_ff      <= setup_value;
					cmd_param_ext_ff <= 8'h00;
				end
				// data stage only for the fetch command, and only when setup_length is nonzero
				cmd_data_stage_ff <= is_ctl && setup_value == `UVCMD_CTL_FETCH &&
				                     setup_length != 16'h0000;
				comm_spu_ok_ff <= is_comm && !straight && c_spu && spu_en_ff;
				comm_prg_ok_ff <= is_comm && !straight && c_prg && prg_en_ff;
				comm_spd_ok_ff <= is_comm && c_spd && spd_chg_en_ff;
			end
		end
	end

	// state report at each interrupt polling interval
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			report_valid_ff <= 1'b0;
			report_state_ff <= 32'h00000000;
		end else begin
			report_valid_ff <= poll_tick;
			if (poll_tick) begin
				report_state_ff <= state_a;
			end
		end
	end

	// avalon slave: one wait cycle, answer at the second edge
	wire wr_take = avs_write && !avs_waitrequest;

	// read mux ahead of the data register, so readdata lands with the answer
	reg  [31:0] nxt_readdata;

	always @* begin
		case (avs_address)
		`UVCMD_REG_CTRL: begin
			nxt_readdata = {31'h00000000, dec_en_ff};
		end
		`UVCMD_REG_STATE_A: begin
			nxt_readdata = state_a;
		end
		`UVCMD_REG_STATE_B: begin
			nxt_readdata = state_b;
		end
		`UVCMD_REG_LAST_CODE: begin
			nxt_readdata = {14'h0000, cmd_class_ff, cmd_code_ff};
		end
		`UVCMD_REG_LAST_PARAM: begin
			nxt_readdata = {8'h00, cmd_param_ext_ff, cmd_param_ff};
		end
		`UVCMD_REG_STALLS: begin
			nxt_readdata = {16'h0000, stall_cnt_ff};
		end
		default: begin
			// unmapped words read as zero
			nxt_readdata = 32'h00000000;
		end
		endcase
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else if (!avs_waitrequest) begin
			avs_waitrequest <= 1'b1;
		end else if (avs_read || avs_write) begin
			avs_waitrequest <= 1'b0;
			if (avs_read) begin
				avs_readdata <= nxt_readdata;
			end
		end
	end

	// control register and stall counter; counter saturates rather than wraps
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			dec_en_ff    <= 1'b1;
			stall_cnt_ff <= 16'h0000;
		end else begin
			if (wr_take && avs_address == `UVCMD_REG_CTRL) begin
				dec_en_ff <= avs_writedata[`UVCMD_CTRL_DEC_EN];
			end
			if (wr_take && avs_address == `UVCMD_REG_STALLS) begin
				stall_cnt_ff <= 16'h0000;
			end else if (ep0_stall_ff && stall_cnt_ff != 16'hffff) begin
				stall_cnt_ff <= stall_cnt_ff + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// File: logic/uvcmd_map.vh
// constants for the vendor command decoder: codes, field positions, register map
`ifndef UVCMD_MAP_VH
`define UVCMD_MAP_VH

// request-type byte: vendor type, device recipient, direction bit free
`define UVCMD_RT_DIR_BIT      7
`define UVCMD_RT_MASK         8'h7f
`define UVCMD_RT_VENDOR_DEV   8'h40

// request byte: command classes
`define UVCMD_REQ_CONTROL     8'h00
`define UVCMD_REQ_COMM        8'h01
`define UVCMD_REQ_MODE        8'h02

// class codes presented on cmd_class
`define UVCMD_CLS_CONTROL     2'h0
`define UVCMD_CLS_COMM        2'h1
`define UVCMD_CLS_MODE        2'h2

// mode command codes (value field)
`define UVCMD_MODE_PULSE_EN   16'h0000
`define UVCMD_MODE_SPEED_EN   16'h0001
`define UVCMD_MODE_SPEED      16'h0002
`define UVCMD_MODE_SPU_DUR    16'h0003
`define UVCMD_MODE_PRG_DUR    16'h0004
`define UVCMD_MODE_SLEW       16'h0005
`define UVCMD_MODE_W1LT       16'h0006
`define UVCMD_MODE_DSO        16'h0007

// control and communication codes the decoder must know
`define UVCMD_CTL_FETCH       16'h0008
`define UVCMD_CTL_LAST        16'h000a
`define UVCMD_COMM_STRAIGHT   8'h80

// embedded bits in a communication command value field
`define UVCMD_COMM_SPU_BIT    0
`define UVCMD_COMM_PRG_BIT    1
`define UVCMD_COMM_SPD_BIT    2

// pulse-enable parameter bits
`define UVCMD_PE_SPU_BIT      0
`define UVCMD_PE_PRG_BIT      1

// speed codes
`define UVCMD_SPEED_REGULAR   3'h0
`define UVCMD_SPEED_FLEX      3'h1
`define UVCMD_SPEED_FAST      3'h2

// power-up values of the setting registers
`define UVCMD_RST_SPU_DUR     8'h20
`define UVCMD_RST_PRG_DUR     8'h40
`define UVCMD_RST_SLEW        3'h5
`define UVCMD_RST_W1LT        3'h4
`define UVCMD_RST_DSO         3'h4

// register word indices on the avalon slave
`define UVCMD_REG_CTRL        3'h0
`define UVCMD_REG_STATE_A     3'h1
`define UVCMD_REG_STATE_B     3'h2
`define UVCMD_REG_LAST_CODE   3'h3
`define UVCMD_REG_LAST_PARAM  3'h4
`define UVCMD_REG_STALLS      3'h5
`define UVCMD_CTRL_DEC_EN     0

`endif

// File: logic/uvcmd_setting.v
// one loadable setting register with its own power-up value
`timescale 1ns/1ps
`default_nettype none
module uvcmd_setting #(
	parameter             WIDTH   = 3,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
	input  wire             mclk,
	input  wire             reset_n,
	input  wire             load,
	input  wire [WIDTH-1:0] nxt_val,
	output reg  [WIDTH-1:0] val_ff
);
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			val_ff <= RST_VAL;
		end else if (load) begin
			val_ff <= nxt_val;
		end
	end
endmodule
`default_nettype wire

// File: verif/uvcmd_decoder_properties.sv
// port-level assertions for the vendor command decoder
`timescale 1ns/1ps
`default_nettype none
module uvcmd_props (
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic        setup_valid,
	input wire logic [7:0]  setup_req_type,
	input wire logic [7:0]  setup_request,
	input wire logic [15:0] setup_value,
	input wire logic [15:0] setup_index,
	input wire logic        poll_tick,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic        cmd_valid_ff,
	input wire logic [1:0]  cmd_class_ff,
	input wire logic [15:0] cmd_code_ff,
	input wire logic [15:0] cmd_param_ff,
	input wire logic [7:0]  cmd_param_ext_ff,
	input wire logic        comm_spu_ok_ff,
	input wire logic        report_valid_ff
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_ans;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	a_bus_one_cycle: assert property (s_req |=> s_ans) else $error("bus answer timing");
	a_bad_rtype: assert property (setup_valid && (setup_req_type & 8'h7f) != 8'h40 |=> !cmd_valid_ff)
		else $error("bad request type accepted");
	a_bad_mode: assert property (setup_valid && setup_request == 8'h02 && setup_value > 16'h0007
		|=> !cmd_valid_ff) else $error("unknown mode accepted");
	a_class_req: assert property (cmd_valid_ff |-> cmd_class_ff == $past(setup_request[1:0]))
		else $error("class mismatch");
	a_param_idx: assert property (cmd_valid_ff |-> cmd_param_ff == $past(setup_index))
		else $error("param mismatch");
	a_code_plain: assert property (cmd_valid_ff && cmd_class_ff != 2'h1
		|-> cmd_code_ff == $past(setup_value)) else $error("code mismatch");
	a_straight_ext: assert property (cmd_valid_ff && cmd_class_ff == 2'h1 && cmd_code_ff == 16'h0080
		|-> cmd_param_ext_ff == $past(setup_value[15:8])) else $error("ext mismatch");
	a_spu_gate: assert property (cmd_valid_ff && comm_spu_ok_ff
		|-> cmd_class_ff == 2'h1 && $past(setup_value[0])) else $error("pullup gate");
	a_poll_report: assert property (poll_tick |=> report_valid_ff)
		else $error("no report");
endmodule
bind uvcmd_decoder uvcmd_props uvcmd_props_i (.*);
`default_nettype wire

// File: verif/uvcmd_host.sv
// host-side model: issues setup packets and poll ticks
`timescale 1ns/1ps
`default_nettype none
module uvcmd_host (
	input  wire logic        mclk,
	output var  logic        setup_valid,
	output var  logic [7:0]  setup_req_type,
	output var  logic [7:0]  setup_request,
	output var  logic [15:0] setup_value,
	output var  logic [15:0] setup_index,
	output var  logic [15:0] setup_length,
	output var  logic        poll_tick
);
	initial begin
		{setup_valid, poll_tick, setup_req_type, setup_request} = '0;
		{setup_value, setup_index, setup_length} = '0;
	end
	task pkt(input logic [7:0] rt, rq, input logic [15:0] v, ix);
		@(posedge mclk);
		setup_valid <= 1'b1;
		setup_req_type <= rt;
		setup_request <= rq;
		setup_value <= v;
		setup_index <= ix;
		setup_length <= (rq == 8'h00 && v == 16'h0008) ? 16'h0008 : 16'h0000;
		@(posedge mclk);
		setup_valid <= 1'b0;
		// stale fields must not look valid
		setup_value <= ~v;
		setup_index <= ~ix;
	endtask
	task tick;
		@(posedge mclk);
		poll_tick <= 1'b1;
		@(posedge mclk);
		poll_tick <= 1'b0;
	endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
// self-checking bench for the vendor command decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        mclk, reset_n, avs_read, avs_write, setup_valid, poll_tick;
	logic [2:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, report_state_ff, q;
	logic [7:0]  setup_req_type, setup_request, cmd_param_ext_ff;
	logic [15:0] setup_value, setup_index, setup_length, cmd_code_ff, cmd_param_ff, v;
	logic [1:0]  cmd_class_ff;
	logic        avs_waitrequest, cmd_valid_ff, cmd_data_stage_ff, ep0_stall_ff;
	logic        comm_spu_ok_ff, comm_prg_ok_ff, comm_spd_ok_ff, report_valid_ff;
	int          error_cnt, compares, k;
	uvcmd_decoder uvcmd_decoder_i (.*);
	uvcmd_host uvcmd_host_i (.*);
	function logic [31:0] st_a(input logic [2:0] s, input logic c, input logic [1:0] p);
		return {13'h0, s, 13'h0, c, p};
	endfunction
	task chk(input string nm, input logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s exp %h got %h", nm, exp, got);
		end
	endtask
	task finish_test;
		if (error_cnt == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
		@(posedge mclk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task pk(input logic [7:0] rt, rq, input logic [15:0] v, ix, input logic [1:0] vs);
		uvcmd_host_i.pkt(rt, rq, v, ix);
		#1;
		chk("valid_stall", {cmd_valid_ff, ep0_stall_ff}, vs);
	endtask
	initial begin
		mclk = 0;
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		#100000;
		error_cnt++;
		finish_test;
	end
	initial begin
		{reset_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
		void'($urandom(32'h38fb));
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		bus(0, 3'h1, 0); chk("state_a", q, 0);
		bus(0, 3'h2, 0); chk("state_b", q, 32'h0445_4020);
		bus(0, 3'h7, 0); chk("unmapped", q, 0);
		for (k = 0; k < 4; k++) begin
			pk(8'h40, 8'h02, 16'h0000, {14'($urandom), k[1:0]}, 2'b10);
			bus(0, 3'h1, 0); chk("pulse_en", q, st_a(0, 0, k[1:0]));
		end
		pk(8'hc0, 8'h02, 16'h0001, {15'($urandom), 1'b1}, 2'b10);
		for (k = 0; k < 3; k++) begin
			pk(8'h40, 8'h02, 16'h0002, {13'($urandom), k[2:0]}, 2'b10);
			bus(0, 3'h1, 0); chk("speed", q, st_a(k[2:0], 1, 3));
		end
		// all enables on: every embedded request passes and loads
		pk(8'h40, 8'h01, 16'h1207, 16'h0133, 2'b10);
		chk("gates_on", {comm_spu_ok_ff, comm_prg_ok_ff, comm_spd_ok_ff}, 3'b111);
		bus(0, 3'h2, 0); chk("dur_load", q, 32'h0445_3333);
		pk(8'h40, 8'h02, 16'h0000, 16'h00fc, 2'b10);
		pk(8'h40, 8'h02, 16'h0001, 16'h0000, 2'b10);
		pk(8'h40, 8'h01, 16'h0007, 16'h0255, 2'b10);
		chk("gates_off", {comm_spu_ok_ff, comm_prg_ok_ff, comm_spd_ok_ff}, 3'b000);
		chk("comm_code", cmd_code_ff, 16'h0007);
		bus(0, 3'h2, 0); chk("dur_kept", q, 32'h0445_3333);
		v = {8'($urandom), 8'h80};
		pk(8'hc0, 8'h01, v, 16'h5aa5, 2'b10);
		chk("straight_ext", cmd_param_ext_ff, v[15:8]);
		chk("straight_code", {cmd_code_ff, cmd_param_ff}, {8'h00, v[7:0], 16'h5aa5});
		bus(0, 3'h3, 0);
		chk("last_code", q, 32'h0001_0080);
		bus(0, 3'h4, 0);
		chk("last_param", q, {8'h00, v[15:8], 16'h5aa5});
		pk(8'hc0, 8'h00, 16'h0008, 16'h0000, 2'b10);
		chk("data_stage", cmd_data_stage_ff, 1);
		pk(8'h40, 8'h00, 16'h0001, 16'h0000, 2'b10);
		chk("no_data_stage", cmd_data_stage_ff, 0);
		pk(8'h40, 8'h02, 16'h0008, 16'h0000, 2'b01);
		pk(8'h41, 8'h00, 16'h0001, 16'h0000, 2'b01);
		pk(8'h40, 8'h03, 16'h0000, 16'h0000, 2'b01);
		pk(8'h40, 8'h00, 16'h000b, 16'h0000, 2'b01);
		bus(0, 3'h5, 0);
		chk("stall_count", q, 4);
		bus(1, 3'h5, 0);
		bus(0, 3'h5, 0);
		chk("stall_clear", q, 0);
		uvcmd_host_i.tick;
		#1;
		chk("report_valid", report_valid_ff, 1);
		chk("report", report_state_ff, st_a(1, 0, 0));
		bus(1, 3'h0, 0);
		pk(8'h40, 8'h02, 16'h0000, 16'h0003, 2'b00);
		bus(1, 3'h0, 1);
		bus(0, 3'h1, 0); chk("ignored", q, st_a(1, 0, 0));
		// mid-run reset must bring every setting back to its power-up value
		pk(8'h40, 8'h02, 16'h0000, 16'h0003, 2'b10);
		@(posedge mclk);
		reset_n <= 1'b0;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		bus(0, 3'h1, 0);
		chk("reset_a", q, 0);
		bus(0, 3'h2, 0);
		chk("reset_b", q, 32'h0445_4020);
		finish_test;
	end
endmodule
`default_nettype wire
